/* hdl/ulfmc_control_regs.v */
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ulfmc_defines.vh"
module ulfmc_control_regs (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [2:0] adr_i,
    input  wire [7:0] dat_i,
    input  wire       we_i,
    input  wire [0:0] sel_i,
    input  wire       cyc_i,
    input  wire       stb_i,
    output reg  [7:0] dat_o,
    output reg        ack_o,
    input  wire       fifo_deep_i,
    input  wire [5:0] tx_level_i,
    input  wire [5:0] rx_level_i,
    input  wire       frame_end_i,
    input  wire       tx_serial_i,
    input  wire       tx_infrared_i,
    input  wire       ir_pulse_train_i,
    input  wire       cts_n_i,
    input  wire       dsr_n_i,
    input  wire       dcd_n_i,
    input  wire       ri_n_i,
    output reg        wired_serial_output_o,
    output reg        infrared_output_o,
    output reg        dtr_n_o,
    output reg        rts_n_o,
    output reg        clear_to_send_o,
    output reg        set_ready_o,
    output reg        carrier_detect_o,
    output reg        ring_indicator_o,
    output reg        irq_enable_o,
    output reg        tx_low_event_o,
    output reg        rx_high_event_o,
    output reg  [1:0] character_length_o,
    output reg  [1:0] stop_bits_o,
    output reg  [2:0] parity_o,
    output reg  [2:0] mode_select_o,
    output reg        fifo_enable_o,
    output reg        dma_mode_enable_o,
    output reg        transmit_deferral_enable_o,
    output reg        interaction_pulse_request_o,
    output reg        tx_soft_reset_o,
    output reg        rx_soft_reset_o,
    output reg        modem_event_clear_o
);

    reg  [7:0] lfc_reg;
    reg  [7:0] bsr_reg;
    reg  [7:0] mcr_reg;
    reg  [7:0] ext1_reg;
    reg  [3:0] thr_reg;
    reg        fifo_en_reg;
    reg        pulse_req_reg;
    reg  [2:0] mode_prev_reg;
    reg  [7:0] rd_next;

    wire [2:0] bank;
    wire       acc;
    wire       wr;
    wire       extended;
    wire       loop;
    wire [2:0] mode;
    wire       low_speed;
    wire [7:0] lfc_eff;
    wire [1:0] tx_code;
    wire [5:0] tx_thr;
    wire [5:0] rx_thr;
    wire       mode_chg;
    wire       wr_fcr;
    wire       wr_link;
    wire       wr_mcr;
    wire       wr_ext1;

    // Bank selection; reserved codes map out every register but the bank select at offset 3
    function [2:0] bank_of;
        input [7:0] b;
        begin
            if (!b[`ULFMC_BANK_EN])
                bank_of = `ULFMC_BANK0;
            else if (!b[6])
                bank_of = `ULFMC_BANK1;
            else if (b == `ULFMC_BSEL_B2)
                bank_of = `ULFMC_BANK2;
            else if (b == `ULFMC_BSEL_B3)
                bank_of = `ULFMC_BANK3;
            else if (b == `ULFMC_BSEL_B4)
                bank_of = `ULFMC_BANK4;
            else if (b == `ULFMC_BSEL_B5)
                bank_of = `ULFMC_BANK5;
            else if (b == `ULFMC_BSEL_B6)
                bank_of = `ULFMC_BANK6;
            else
                bank_of = `ULFMC_BANK_RSVD;
        end
    endfunction

    function [5:0] thresh;
        input [1:0] c;
        input       deep;
        input       rx;
        begin
            case ({rx, deep, c})
                4'b0000: thresh = `ULFMC_TX16_0;
                4'b0001: thresh = `ULFMC_TX16_1;
                4'b0010: thresh = `ULFMC_TX16_2;
                4'b0011: thresh = `ULFMC_TX16_3;
                4'b0100: thresh = `ULFMC_TX32_0;
                4'b0101: thresh = `ULFMC_TX32_1;
                4'b0110: thresh = `ULFMC_TX32_2;
                4'b0111: thresh = `ULFMC_TX32_3;
                4'b1000: thresh = `ULFMC_RX16_0;
                4'b1001: thresh = `ULFMC_RX16_1;
                4'b1010: thresh = `ULFMC_RX16_2;
                4'b1011: thresh = `ULFMC_RX16_3;
                4'b1100: thresh = `ULFMC_RX32_0;
                4'b1101: thresh = `ULFMC_RX32_1;
                4'b1110: thresh = `ULFMC_RX32_2;
                default: thresh = `ULFMC_RX32_3;
            endcase
        end
    endfunction

    assign bank      = bank_of(bsr_reg);
    assign acc       = cyc_i & stb_i;
    // Writes land on the acknowledge edge, so the next access sees the new bank
    assign wr        = acc & ack_o & we_i & sel_i[0];
    assign wr_link   = wr & (adr_i == `ULFMC_OFS_LINK_BANK);
    assign wr_fcr    = wr & (bank == `ULFMC_BANK0) & (adr_i == `ULFMC_OFS_FIFO_CTL);
    assign wr_mcr    = wr & (bank == `ULFMC_BANK0) & (adr_i == `ULFMC_OFS_MODEM_CTL);
    assign wr_ext1   = wr & (bank == `ULFMC_BANK2) & (adr_i == `ULFMC_OFS_EXT_CTL1);

    assign extended  = ext1_reg[`ULFMC_EXT_EN];
    assign loop      = ext1_reg[`ULFMC_EXT_LOOP];
    // Mode bits are reserved outside extended mode, so the block runs as plain UART
    assign mode      = extended ? mcr_reg[7:5] : `ULFMC_MODE_UART;
    assign low_speed = (mode == `ULFMC_MODE_UART) | (mode == `ULFMC_MODE_ASK) |
                       (mode == `ULFMC_MODE_SIR);
    assign lfc_eff   = low_speed ? lfc_reg : 8'h00;
    assign tx_code   = extended ? thr_reg[1:0] : 2'b00;
    assign tx_thr    = thresh(tx_code, fifo_deep_i, 1'b0);
    assign rx_thr    = thresh(thr_reg[3:2], fifo_deep_i, 1'b1);
    assign mode_chg  = (mode != mode_prev_reg);

    always @(posedge clk_i) begin
        if (rst_i) begin
            lfc_reg       <= `ULFMC_RST_LFC;
            bsr_reg       <= `ULFMC_RST_BSR;
            mcr_reg       <= `ULFMC_RST_MCR;
            ext1_reg      <= `ULFMC_RST_EXT1;
            thr_reg       <= 4'h0;
            fifo_en_reg   <= 1'b0;
            pulse_req_reg <= 1'b0;
            mode_prev_reg <= `ULFMC_MODE_UART;
        end else begin
            mode_prev_reg <= mode;
            if (wr_link) begin
                bsr_reg <= dat_i;
                if (!dat_i[`ULFMC_BANK_EN])
                    lfc_reg <= {1'b0, dat_i[6:0]};
            end
            if (wr_fcr) begin
                thr_reg     <= dat_i[7:4];
                fifo_en_reg <= dat_i[`ULFMC_FCR_EN];
            end
            if (wr_mcr) begin
                mcr_reg[3:0] <= dat_i[3:0];
                if (extended)
                    mcr_reg[7:5] <= dat_i[7:5];
                else
                    ext1_reg[`ULFMC_EXT_LOOP] <= dat_i[`ULFMC_MCR_LOOP];
            end
            if (wr_ext1)
                ext1_reg <= dat_i;
            // Software set wins over the end-of-frame or soft-reset clear
            if (wr_mcr & extended & dat_i[`ULFMC_MCR_LOOP])
                pulse_req_reg <= 1'b1;
            else if (frame_end_i | tx_soft_reset_o)
                pulse_req_reg <= 1'b0;
        end
    end

    always @* begin
        rd_next = 8'h00;
        if (adr_i == `ULFMC_OFS_LINK_BANK)
            rd_next = bsr_reg;
        else if (bank == `ULFMC_BANK0 && adr_i == `ULFMC_OFS_MODEM_CTL) begin
            if (extended)
                rd_next = {mcr_reg[7:5], pulse_req_reg, mcr_reg[3:0]};
            else
                rd_next = {3'b000, loop, mcr_reg[3:0]};
        end else if (bank == `ULFMC_BANK0 && adr_i == `ULFMC_OFS_STATUS)
            rd_next = {mode, extended, loop, fifo_en_reg, rx_high_event_o, tx_low_event_o};
        else if (bank == `ULFMC_BANK2 && adr_i == `ULFMC_OFS_EXT_CTL1)
            rd_next = ext1_reg;
        else if (bank == `ULFMC_BANK3 && adr_i == `ULFMC_OFS_SHADOW)
            rd_next = lfc_reg;
    end

    // Bus slave: one wait state, ack dropped in the cycle after it was given
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 8'h00;
        end else begin
            ack_o <= acc & ~ack_o;
            if (acc & ~ack_o & ~we_i)
                dat_o <= rd_next;
        end
    end

    // Format, modem and front-end outputs, all registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            wired_serial_output_o       <= 1'b1;
            infrared_output_o           <= 1'b0;
            dtr_n_o                     <= 1'b1;
            rts_n_o                     <= 1'b1;
            clear_to_send_o             <= 1'b0;
            set_ready_o                 <= 1'b0;
            carrier_detect_o            <= 1'b0;
            ring_indicator_o            <= 1'b0;
            irq_enable_o                <= 1'b0;
            tx_low_event_o              <= 1'b0;
            rx_high_event_o             <= 1'b0;
            character_length_o          <= 2'b00;
            stop_bits_o                 <= `ULFMC_STOP_ONE;
            parity_o                    <= `ULFMC_PAR_NONE;
            mode_select_o               <= `ULFMC_MODE_UART;
            fifo_enable_o               <= 1'b0;
            dma_mode_enable_o           <= 1'b0;
            transmit_deferral_enable_o  <= 1'b0;
            interaction_pulse_request_o <= 1'b0;
            tx_soft_reset_o             <= 1'b0;
            rx_soft_reset_o             <= 1'b0;
            modem_event_clear_o         <= 1'b0;
        end else begin
            tx_low_event_o  <= (tx_level_i < tx_thr);
            rx_high_event_o <= (rx_level_i >= rx_thr);
            character_length_o <= lfc_eff[1:0];
            // Receiver ignores this; it always checks a single stop bit
            if (!lfc_eff[`ULFMC_LFC_STOP])
                stop_bits_o <= `ULFMC_STOP_ONE;
            else if (lfc_eff[1:0] == 2'b00)
                stop_bits_o <= `ULFMC_STOP_ONE_HALF;
            else
                stop_bits_o <= `ULFMC_STOP_TWO;
            case ({lfc_eff[`ULFMC_LFC_PEN], lfc_eff[`ULFMC_LFC_STICK], lfc_eff[`ULFMC_LFC_EVEN]})
                3'b100:  parity_o <= `ULFMC_PAR_ODD;
                3'b101:  parity_o <= `ULFMC_PAR_EVEN;
                3'b110:  parity_o <= `ULFMC_PAR_ONE;
                3'b111:  parity_o <= `ULFMC_PAR_ZERO;
                default: parity_o <= `ULFMC_PAR_NONE;
            endcase
            // Break only overrides the front-end; the transmitter keeps running
            if (lfc_eff[`ULFMC_LFC_BREAK] && mode == `ULFMC_MODE_UART)
                wired_serial_output_o <= 1'b0;
            else
                wired_serial_output_o <= tx_serial_i;
            if (lfc_eff[`ULFMC_LFC_BREAK] && mode == `ULFMC_MODE_SIR)
                infrared_output_o <= ir_pulse_train_i;
            else if (lfc_eff[`ULFMC_LFC_BREAK] && mode == `ULFMC_MODE_ASK)
                infrared_output_o <= ext1_reg[`ULFMC_EXT_INTMOD] ? ir_pulse_train_i
                                                                  : 1'b1;
            else
                infrared_output_o <= tx_infrared_i;
            // Loopback parks the modem pins inactive and feeds the inputs back
            dtr_n_o <= loop | ~mcr_reg[`ULFMC_MCR_DTR];
            rts_n_o <= loop | ~mcr_reg[`ULFMC_MCR_RTS];
            if (loop) begin
                set_ready_o     <= mcr_reg[`ULFMC_MCR_DTR];
                clear_to_send_o <= mcr_reg[`ULFMC_MCR_RTS];
                if (extended) begin
                    ring_indicator_o <= mcr_reg[`ULFMC_MCR_DTR];
                    carrier_detect_o <= mcr_reg[`ULFMC_MCR_RTS];
                end else begin
                    ring_indicator_o <= mcr_reg[`ULFMC_MCR_RING];
                    carrier_detect_o <= mcr_reg[`ULFMC_MCR_ISEN];
                end
            end else begin
                set_ready_o      <= ~dsr_n_i;
                clear_to_send_o  <= ~cts_n_i;
                ring_indicator_o <= ~ri_n_i;
                carrier_detect_o <= ~dcd_n_i;
            end
            irq_enable_o <= extended | loop | mcr_reg[`ULFMC_MCR_ISEN];
            mode_select_o <= mode;
            fifo_enable_o <= fifo_en_reg | (mode == `ULFMC_MODE_MIR) |
                             (mode == `ULFMC_MODE_FIR) | (mode == `ULFMC_MODE_CONSUMER_INFRARED_MODE);
            dma_mode_enable_o          <= extended & mcr_reg[`ULFMC_MCR_RING];
            transmit_deferral_enable_o <= extended & mcr_reg[`ULFMC_MCR_ISEN];
            interaction_pulse_request_o <= pulse_req_reg;
            tx_soft_reset_o     <= mode_chg | (wr_fcr & dat_i[`ULFMC_FCR_TXSR]);
            rx_soft_reset_o     <= mode_chg | (wr_fcr & dat_i[`ULFMC_FCR_RXSR]);
            modem_event_clear_o <= mode_chg;
        end
    end

endmodule // ulfmc_control_regs
`default_nettype wire

/* include/ulfmc_defines.vh */
`ifndef ULFMC_DEFINES_VH
`define ULFMC_DEFINES_VH
// Byte offsets within the selected bank
`define ULFMC_OFS_FIFO_CTL    3'h2
`define ULFMC_OFS_LINK_BANK   3'h3
`define ULFMC_OFS_MODEM_CTL   3'h4
`define ULFMC_OFS_STATUS      3'h5
`define ULFMC_OFS_EXT_CTL1    3'h2
`define ULFMC_OFS_SHADOW      3'h5
// Bank numbers
`define ULFMC_BANK0           3'h0
`define ULFMC_BANK1           3'h1
`define ULFMC_BANK2           3'h2
`define ULFMC_BANK3           3'h3
`define ULFMC_BANK4           3'h4
`define ULFMC_BANK5           3'h5
`define ULFMC_BANK6           3'h6
`define ULFMC_BANK_RSVD       3'h7
// Bank select codes with the enable bit set
`define ULFMC_BSEL_B2         8'he0
`define ULFMC_BSEL_B3         8'he4
`define ULFMC_BSEL_B4         8'he8
`define ULFMC_BSEL_B5         8'hec
`define ULFMC_BSEL_B6         8'hf0
// Operating modes
`define ULFMC_MODE_UART       3'h0
`define ULFMC_MODE_ASK        3'h2
`define ULFMC_MODE_SIR        3'h3
`define ULFMC_MODE_MIR        3'h4
`define ULFMC_MODE_FIR        3'h5
`define ULFMC_MODE_CONSUMER_INFRARED_MODE       3'h6
// Link format field positions
`define ULFMC_LFC_STOP        2
`define ULFMC_LFC_PEN         3
`define ULFMC_LFC_EVEN        4
`define ULFMC_LFC_STICK       5
`define ULFMC_LFC_BREAK       6
`define ULFMC_BANK_EN         7
// Modem and mode control field positions
`define ULFMC_MCR_DTR         0
`define ULFMC_MCR_RTS         1
`define ULFMC_MCR_RING        2
`define ULFMC_MCR_ISEN        3
`define ULFMC_MCR_LOOP        4
// First extended control field positions
`define ULFMC_EXT_EN          0
`define ULFMC_EXT_LOOP        4
`define ULFMC_EXT_INTMOD      5
// FIFO control field positions
`define ULFMC_FCR_EN          0
`define ULFMC_FCR_RXSR        1
`define ULFMC_FCR_TXSR        2
// Reset values
`define ULFMC_RST_LFC         8'h00
`define ULFMC_RST_BSR         8'h00
`define ULFMC_RST_MCR         8'h00
`define ULFMC_RST_EXT1        8'h00
`define ULFMC_RST_FCR         8'h00
// Thresholds for 16-deep and 32-deep FIFOs
`define ULFMC_TX16_0          6'h01
`define ULFMC_TX16_1          6'h03
`define ULFMC_TX16_2          6'h09
`define ULFMC_TX16_3          6'h0d
`define ULFMC_TX32_0          6'h01
`define ULFMC_TX32_1          6'h07
`define ULFMC_TX32_2          6'h11
`define ULFMC_TX32_3          6'h19
`define ULFMC_RX16_0          6'h01
`define ULFMC_RX16_1          6'h04
`define ULFMC_RX16_2          6'h08
`define ULFMC_RX16_3          6'h0e
`define ULFMC_RX32_0          6'h01
`define ULFMC_RX32_1          6'h08
`define ULFMC_RX32_2          6'h10
`define ULFMC_RX32_3          6'h1a
// Parity and stop encodings on the format outputs
`define ULFMC_PAR_NONE        3'h0
`define ULFMC_PAR_ODD         3'h1
`define ULFMC_PAR_EVEN        3'h2
`define ULFMC_PAR_ONE         3'h3
`define ULFMC_PAR_ZERO        3'h4
`define ULFMC_STOP_ONE        2'h0
`define ULFMC_STOP_ONE_HALF   2'h1
`define ULFMC_STOP_TWO        2'h2
`endif

/* tb/tb_ulfmc_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ulfmc_defines.vh"
module tb_ulfmc_control_regs;
    localparam logic [5:0] TH [16] = '{6'h01, 6'h03, 6'h09, 6'h0d, 6'h01, 6'h07, 6'h11, 6'h19,
        6'h01, 6'h04, 6'h08, 6'h0e, 6'h01, 6'h08, 6'h10, 6'h1a};
    logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, carrier = 0, ring = 0;
    logic [2:0] adr_i = 3'h0;
    logic [7:0] dat_i = 8'h00;
    logic [0:0] sel_i = 1'h1;
    logic fifo_deep_i = 0, frame_end_i = 0, tx_serial_i = 1, tx_infrared_i = 0;
    logic ir_pulse_train_i = 0;
    logic [5:0] tx_level_i = 6'h00, rx_level_i = 6'h00;
    logic cts_n_i, dsr_n_i, dcd_n_i, ri_n_i, ack_o, wired_serial_output_o, infrared_output_o;
    logic dtr_n_o, rts_n_o, clear_to_send_o, set_ready_o, carrier_detect_o, ring_indicator_o;
    logic irq_enable_o, tx_low_event_o, rx_high_event_o, fifo_enable_o, dma_mode_enable_o;
    logic transmit_deferral_enable_o, interaction_pulse_request_o, tx_soft_reset_o;
    logic rx_soft_reset_o, modem_event_clear_o;
    logic [7:0] dat_o, mdm;
    logic [1:0] character_length_o, stop_bits_o;
    logic [2:0] parity_o, mode_select_o;
    int cmp_count = 0, miscompares = 0, cycles = 0;
    assign mdm = {dtr_n_o, rts_n_o, set_ready_o, clear_to_send_o, carrier_detect_o,
        ring_indicator_o, irq_enable_o, 1'b0};
    ulfmc_control_regs u_dut (.*);
    ulfmc_modem_model #(.LAG(3)) u_modem (.clk_i(clk_i), .dtr_n_i(dtr_n_o), .rts_n_i(rts_n_o),
        .carrier_i(carrier), .ring_i(ring), .dsr_n_o(dsr_n_i), .cts_n_o(cts_n_i),
        .dcd_n_o(dcd_n_i), .ri_n_o(ri_n_i));
    always #2.5 clk_i = ~clk_i;
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Bound on the whole run; the sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            test_done;
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    // Outputs lag by a clock and the modem answers late, so allow both
    task automatic settle;
        repeat (6) @(posedge clk_i);
        #1;
    endtask
    task automatic set_mode(input logic [2:0] m);
        logic seen;
        seen = 1'b0;
        wr(3'h4, {m, 5'h00});
        repeat (4) begin
            @(posedge clk_i);
            #1;
            seen |= modem_event_clear_o;
        end
        chk({seen, 4'h0, mode_select_o}, {1'b1, 4'h0, m});
    endtask
    task automatic ir_chk(input logic p, input logic e);
        ir_pulse_train_i <= p;
        settle;
        chk({7'h00, infrared_output_o}, {7'h00, e});
    endtask
    task automatic t_reset;
        chk({4'h0, dtr_n_o, rts_n_o, wired_serial_output_o, infrared_output_o}, 8'h0e);
        rdc(3'h3, 8'h00);
        rdc(3'h4, 8'h00);
        wr(3'h3, `ULFMC_BSEL_B3);
        rdc(3'h5, 8'h00);
        wr(3'h3, 8'h00);
    endtask
    task automatic t_format;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 8'(i * 9);
            wr(3'h3, v);
            settle;
            chk({1'b0, parity_o, stop_bits_o, character_length_o}, {1'b0, v[3] ? 3'h1 +
                {1'b0, v[5:4]} : 3'h0, v[2] ? (v[1:0] == 2'h0 ? 2'h1 : 2'h2) : 2'h0, v[1:0]});
        end
    endtask
    task automatic t_bank;
        wr(3'h3, 8'h9b);
        rdc(3'h3, 8'h9b);
        wr(3'h3, `ULFMC_BSEL_B3);
        rdc(3'h5, 8'h3f);
        sel_i <= 1'h0;
        wr(3'h3, 8'h00);
        sel_i <= 1'h1;
        rdc(3'h3, 8'he4);
        wr(3'h3, 8'hf8);
        rdc(3'h5, 8'h00);
        wr(3'h3, 8'h12);
        rdc(3'h3, 8'h12);
        rdc(3'h7, 8'h00);
        wr(3'h3, `ULFMC_BSEL_B3);
        rdc(3'h5, 8'h12);
        wr(3'h3, 8'h03);
    endtask
    task automatic t_modem;
        wr(3'h4, 8'h03);
        settle;
        chk(mdm, 8'h30);
        carrier <= 1'b1;
        wr(3'h4, 8'h0c);
        settle;
        chk(mdm, 8'hca);
        carrier <= 1'b0;
        wr(3'h4, 8'h1d);
        settle;
        chk(mdm, 8'hee);
        wr(3'h3, `ULFMC_BSEL_B2);
        rdc(3'h2, 8'h10);
        wr(3'h2, 8'h11);
        wr(3'h3, 8'h03);
        wr(3'h4, 8'h02);
        settle;
        chk(mdm, 8'hda);
        wr(3'h4, 8'h01);
        settle;
        chk(mdm, 8'he6);
        wr(3'h4, 8'h1c);
        settle;
        chk({5'h00, dma_mode_enable_o, transmit_deferral_enable_o, interaction_pulse_request_o}, 8'h07);
        rdc(3'h4, 8'h1c);
        @(posedge clk_i);
        frame_end_i <= 1'b1;
        @(posedge clk_i);
        frame_end_i <= 1'b0;
        settle;
        chk({5'h00, dma_mode_enable_o, transmit_deferral_enable_o, interaction_pulse_request_o}, 8'h06);
        wr(3'h4, 8'h01);
        wr(3'h3, `ULFMC_BSEL_B2);
        wr(3'h2, 8'h01);
        wr(3'h3, 8'h03);
        ring <= 1'b1;
        settle;
        chk(mdm, 8'h66);
    endtask
    task automatic t_break;
        wr(3'h3, 8'h43); // nothing is queued, so the transmitter is idle
        settle;
        chk({7'h00, wired_serial_output_o}, 8'h00);
        set_mode(`ULFMC_MODE_SIR);
        ir_chk(1'b1, 1'b1);
        ir_chk(1'b0, 1'b0);
        set_mode(`ULFMC_MODE_ASK);
        ir_chk(1'b0, 1'b1);
        wr(3'h3, `ULFMC_BSEL_B2);
        wr(3'h2, 8'h21);
        wr(3'h3, 8'h43);
        ir_chk(1'b1, 1'b1);
        ir_chk(1'b0, 1'b0);
        set_mode(`ULFMC_MODE_MIR);
        settle;
        chk({fifo_enable_o, parity_o, stop_bits_o, character_length_o}, 8'h80);
        wr(3'h3, `ULFMC_BSEL_B3);
        rdc(3'h5, 8'h43);
        wr(3'h3, 8'h43);
        set_mode(`ULFMC_MODE_FIR);
        set_mode(`ULFMC_MODE_CONSUMER_INFRARED_MODE);
        set_mode(`ULFMC_MODE_UART);
        wr(3'h3, 8'h03);
        settle;
        chk({7'h00, wired_serial_output_o}, 8'h01);
    endtask
    task automatic t_fifo;
        for (int i = 0; i < 8; i++) begin
            fifo_deep_i <= i[2];
            wr(3'h2, {i[1:0], i[1:0], 4'h1});
            tx_level_i <= TH[i] - 6'h01;
            rx_level_i <= TH[i+8] - 6'h01;
            settle;
            chk({6'h00, tx_low_event_o, rx_high_event_o}, 8'h02);
            tx_level_i <= TH[i];
            rx_level_i <= TH[i+8];
            settle;
            chk({6'h00, tx_low_event_o, rx_high_event_o}, 8'h01);
        end
        rdc(3'h2, 8'h00);
        wr(3'h3, `ULFMC_BSEL_B2);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h03);
        wr(3'h2, 8'h31);
        tx_level_i <= 6'h01;
        rx_level_i <= 6'h00;
        settle;
        chk({5'h00, fifo_enable_o, tx_low_event_o, rx_high_event_o}, 8'h04);
        // Soft reset strobes stand for one cycle right after the write edge
        wr(3'h2, 8'h06);
        #1;
        chk({6'h00, tx_soft_reset_o, rx_soft_reset_o}, 8'h03);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        t_reset;
        t_format;
        t_bank;
        t_modem;
        t_break;
        t_fifo;
        test_done;
    end
endmodule // tb_ulfmc_control_regs
`default_nettype wire

/* tb/ulfmc_control_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ulfmc_defines.vh"
module ulfmc_chk (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire logic [5:0] tx_level_i,
    input wire logic [5:0] rx_level_i,
    input wire logic       tx_low_event_o,
    input wire logic       rx_high_event_o,
    input wire logic [2:0] mode_select_o,
    input wire logic [1:0] character_length_o,
    input wire logic [1:0] stop_bits_o,
    input wire logic [2:0] parity_o,
    input wire logic       tx_soft_reset_o,
    input wire logic       rx_soft_reset_o,
    input wire logic       modem_event_clear_o,
    input wire logic       dtr_n_o,
    input wire logic       rts_n_o,
    input wire logic       set_ready_o,
    input wire logic       clear_to_send_o,
    input wire logic       dsr_n_i,
    input wire logic       cts_n_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack;
        ack_o ##1 !ack_o;
    endsequence
    ack_answer_a: assert property (s_req |=> s_ack)
        else $error("bus answer late or long");
    fmt_ignore_a: assert property (mode_select_o inside {`ULFMC_MODE_MIR, `ULFMC_MODE_FIR,
        `ULFMC_MODE_CONSUMER_INFRARED_MODE} |-> {parity_o, stop_bits_o, character_length_o} == 7'h00)
        else $error("format active in fast mode");
    stop_len_a: assert property (stop_bits_o != `ULFMC_STOP_ONE |->
        (stop_bits_o == `ULFMC_STOP_ONE_HALF) == (character_length_o == 2'h0))
        else $error("stop count wrong for length");
    rx_event_a: assert property (!$past(rst_i) && ($past(rx_level_i) == 6'h00 ||
        $past(rx_level_i) >= 6'h1a) |-> rx_high_event_o == ($past(rx_level_i) != 6'h00))
        else $error("receive event wrong");
    tx_event_a: assert property (!$past(rst_i) && ($past(tx_level_i) == 6'h00 ||
        $past(tx_level_i) >= 6'h19) |-> tx_low_event_o == ($past(tx_level_i) == 6'h00))
        else $error("transmit event wrong");
    clr_pulse_a: assert property (modem_event_clear_o |->
        tx_soft_reset_o && rx_soft_reset_o ##1 !modem_event_clear_o)
        else $error("mode change resets wrong");
    dtr_path_a: assert property (!$past(rst_i) && !dtr_n_o |-> set_ready_o == !$past(dsr_n_i))
        else $error("set ready not from pin");
    rts_path_a: assert property (!$past(rst_i) && !rts_n_o |-> clear_to_send_o == !$past(cts_n_i))
        else $error("clear to send not from pin");
endmodule // ulfmc_chk
bind ulfmc_control_regs ulfmc_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .tx_level_i,
    .rx_level_i, .tx_low_event_o, .rx_high_event_o, .mode_select_o, .character_length_o,
    .stop_bits_o, .parity_o, .tx_soft_reset_o, .rx_soft_reset_o, .modem_event_clear_o,
    .dtr_n_o, .rts_n_o, .set_ready_o, .clear_to_send_o, .dsr_n_i, .cts_n_i);
`default_nettype wire

/* tb/ulfmc_modem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ulfmc_modem_model #(
    parameter int LAG = 3
) (
    input  wire logic clk_i,
    input  wire logic dtr_n_i,
    input  wire logic rts_n_i,
    input  wire logic carrier_i,
    input  wire logic ring_i,
    output var  logic dsr_n_o,
    output var  logic cts_n_o,
    output var  logic dcd_n_o,
    output var  logic ri_n_o
);
    // A slow data set: ready and clear answer several clocks late
    logic [7:0] dtr_q = 8'hff;
    logic [7:0] rts_q = 8'hff;
    always @(posedge clk_i) begin
        dtr_q <= {dtr_q[6:0], dtr_n_i};
        rts_q <= {rts_q[6:0], rts_n_i};
    end
    always_comb begin
        dsr_n_o = dtr_q[LAG-1];
        cts_n_o = rts_q[LAG-1];
        dcd_n_o = ~carrier_i;
        ri_n_o  = ~ring_i;
    end
endmodule // ulfmc_modem_model
`default_nettype wire
